// ===== dv/cs4_monitor.sv
`default_nettype none

module cs4_monitor
    import cs4_pkg::*;
(
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    input  wire logic                       cyc_i,
    input  wire logic                       stb_i,
    input  wire logic                       we_i,
    input  wire logic [cs4_pkg::WB_DW-1:0]  dat_o,
    input  wire logic                       ack_o,
    input  wire logic                       edge_clock_i,
    input  wire logic                       master_clear_i,
    input  wire logic [cs4_pkg::STAGES-1:0] q_o,
    input  wire logic                       terminal_count_n_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not acknowledged next cycle");
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    rdata_hold_a: assert property ($changed(dat_o) |-> ack_o && !we_i)
        else $error("read data moved outside a read");
    mclear_zero_a: assert property (master_clear_i |-> q_o == STAGE_RST)
        else $error("stages not clear under master clear");
    mclear_release_a: assert property ($fell(master_clear_i) |-> q_o == STAGE_RST)
        else $error("stages not clear at master clear release");
    q_change_cause_a: assert property ($changed(q_o) |-> master_clear_i
        || $past(master_clear_i) || $past(ack_o) || $past(ack_o, 2) || $past(ack_o, 3)
        || $past(edge_clock_i, 2) || $past(edge_clock_i, 3) || $past(edge_clock_i, 4)
        || $past(edge_clock_i, 5))
        else $error("stages changed without a step");
    tc_low_cause_a: assert property (!terminal_count_n_o |-> q_o == STAGE_MAX || !q_o[3])
        else $error("terminal count low at a middle value");

    cover property (master_clear_i);
    cover property (!terminal_count_n_o && q_o == STAGE_MAX);
    cover property (ack_o && !we_i);
    cover property ($rose(edge_clock_i));
endmodule

`default_nettype wire

// ===== dv/cs4_neighbour.sv
`default_nettype none

// the stage below presents its terminal count, the stage above its lowest bit
module cs4_neighbour (
    input  wire logic clk_i,
    input  wire logic lower_tc_n_i,
    input  wire logic upper_q0_i,
    output logic      trickle_n_o,
    output logic      serial_o
);
    timeunit 1ns;
    timeprecision 1ns;
    always_ff @(posedge clk_i) begin
        trickle_n_o <= lower_tc_n_i;
        serial_o    <= upper_q0_i;
    end
endmodule

`default_nettype wire

// ===== dv/tb_top.sv
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import cs4_pkg::*;

    logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, edge_clock_i, master_clear_i;
    logic        trickle_n, serial_dn, lower_tc_n, upper_q0, tc_n;
    logic [7:0]  adr_i;
    logic [31:0] dat_i, dat_o, rd;
    logic [3:0]  q_o;
    logic [19:0] r;
    int          error_cnt, n_checks, cyc_cnt;

    // start, second preset, select, {cep_n, trickle_n, serial, tc_n}, result
    localparam logic [19:0] ROWS [14] = '{20'h3b01b, 20'he030f, 20'hf0310, 20'h10100,
        20'h0011f, 20'h40394, 20'h40354, 20'h5065b, 20'h40618, 20'h6023b, 20'h90204,
        20'h5041a, 20'h70510, 20'h90719};

    cs4_counter_shift uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .edge_clock_i(edge_clock_i), .count_enable_trickle_n_i(trickle_n),
        .shift_down_serial_i(serial_dn), .master_clear_i(master_clear_i), .q_o(q_o),
        .terminal_count_n_o(tc_n));

    cs4_neighbour nb (.clk_i(clk_i), .lower_tc_n_i(lower_tc_n), .upper_q0_i(upper_q0),
        .trickle_n_o(trickle_n), .serial_o(serial_dn));

    always #20 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 5000) begin
            error_cnt++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask

    task automatic load_mode(input logic [3:0] v, input logic [3:0] m);
        wb(1'b1, PRESET_OFS, {28'h0, v});
        wb(1'b1, CTRL_OFS, {28'h1, m});
        wb(1'b1, STEP_OFS, 32'h1);
    endtask

    initial begin
        clk_i = 1'b0;
        rst_i = 1'b1;
        {cyc_i, stb_i, we_i, edge_clock_i, master_clear_i, lower_tc_n, upper_q0} = '0;
        adr_i = '0;
        dat_i = '0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, CTRL_OFS, 32'h0);
        chk(rd, 32'h17);
        wb(1'b0, STATUS_OFS, 32'h0);
        chk(rd, 32'h10);
        wb(1'b1, 8'h20, 32'hff);
        wb(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0);
        wb(1'b1, WRAPS_OFS, 32'h0);
        foreach (ROWS[i]) begin
            r = ROWS[i];
            lower_tc_n <= r[6];
            upper_q0   <= r[5];
            load_mode(r[19:16], {1'b0, SEL_LOAD});
            load_mode(r[15:12], {r[7], r[10:8]});
            wb(1'b0, STATUS_OFS, 32'h0);
            chk(rd[6:0], {r[5], r[6], r[4:0]});
            chk({tc_n, q_o}, r[4:0]);
        end
        wb(1'b0, WRAPS_OFS, 32'h0);
        chk(rd, 32'h2);
        wb(1'b1, STEPS_OFS, 32'h0);
        lower_tc_n <= 1'b0;
        load_mode(4'h7, {1'b0, SEL_LOAD});
        wb(1'b1, CTRL_OFS, {28'h1, 1'b0, SEL_CUP});
        @(posedge clk_i);
        edge_clock_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        edge_clock_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        chk(q_o, 4'h8);
        wb(1'b0, STEPS_OFS, 32'h0);
        chk(rd, 32'h2);
        load_mode(4'hf, {1'b0, SEL_LOAD});
        wb(1'b1, CTRL_OFS, {28'h1, 1'b0, SEL_CUP});
        @(posedge clk_i);
        master_clear_i <= 1'b1;
        #1;
        chk(q_o, 4'h0);
        wb(1'b1, STEP_OFS, 32'h1);
        repeat (3) @(posedge clk_i);
        chk(q_o, 4'h0);
        master_clear_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk(q_o, 4'h0);
        load_mode(4'h5, {1'b0, SEL_LOAD});
        wb(1'b0, STATUS_OFS, 32'h0);
        chk(rd, 32'h15);
        // mid-run reset with the clock pin already high: no false step may follow
        rst_i        <= 1'b1;
        edge_clock_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        chk(q_o, 4'h0);
        wb(1'b0, CTRL_OFS, 32'h0);
        chk(rd, 32'h17);
        wb(1'b0, STEPS_OFS, 32'h0);
        chk(rd, 32'h0);
        report_and_stop();
    end
endmodule

bind cs4_counter_shift cs4_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .dat_o(dat_o), .ack_o(ack_o), .edge_clock_i(edge_clock_i),
    .master_clear_i(master_clear_i), .q_o(q_o), .terminal_count_n_o(terminal_count_n_o));

`default_nettype wire

// ===== hdl/cs4_counter_shift.sv
// How it works
// - the four stages act either as a wrapping modulo-16 up/down counter or a bidirectional shifter.
// - the three select bits s2 s1 s0 pick load, shift down, shift up, count down/up, hold, complement, clear.
// - counting advances only while both active-low count enables are low, else the count holds.
// - shift up takes its serial bit from the trickle count enable input.
// - shift down takes its serial bit from the shift-down serial input.
// - in counting modes terminal count goes low at 15 counting up or at 0 counting down.
// - in shift modes terminal count copies the most significant stage.
// - load copies the four preset bits into the stages in parallel.
// - a high master clear empties all stages at once, without the clock, above everything else.
// - complement inverts every stage on the active edge.
// - every operation but master clear happens on a rising edge step, and hold keeps the value.
//
// Design decisions made here: register access over Wishbone and the register offsets.
`default_nettype none

module cs4_counter_shift
    import cs4_pkg::*;
#(
    parameter int CW = CNT_W
) (
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    // wishbone classic slave
    input  wire logic                          cyc_i,
    input  wire logic                          stb_i,
    input  wire logic                          we_i,
    input  wire logic [cs4_pkg::WB_AW-1:0]     adr_i,
    input  wire logic [3:0]                    sel_i,
    input  wire logic [cs4_pkg::WB_DW-1:0]     dat_i,
    output logic      [cs4_pkg::WB_DW-1:0]     dat_o,
    output logic                               ack_o,
    // cascade and clocking pins
    input  wire logic                          edge_clock_i,
    input  wire logic                          count_enable_trickle_n_i,
    input  wire logic                          shift_down_serial_i,
    input  wire logic                          master_clear_i,
    output logic      [cs4_pkg::STAGES-1:0]    q_o,
    output logic                               terminal_count_n_o
);

    import cs4_pkg::*;

    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    logic [2:0] pins_async;
    logic [2:0] pins_sync;
    logic       edge_clock_s;
    logic       trickle_n_s;
    logic       serial_down_s;

    assign pins_async = {edge_clock_i, count_enable_trickle_n_i, shift_down_serial_i};

    cs4_sync #(
        .W (3)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i (pins_async),
        .sync_o  (pins_sync)
    );

    assign edge_clock_s  = pins_sync[2];
    assign trickle_n_s   = pins_sync[1];
    assign serial_down_s = pins_sync[0];

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    logic       ack_reg;
    logic       bus_req;
    logic       bus_wr;
    logic       lane0;
    logic       hit_ctrl;
    logic       hit_preset;
    logic       hit_step;
    logic       hit_steps;
    logic       hit_wraps;

    assign bus_req    = cyc_i && stb_i;
    // write commits at the edge where the master sees ack
    assign bus_wr     = bus_req && we_i && ack_reg;
    assign lane0      = sel_i[0];
    assign hit_ctrl   = (adr_i == CTRL_OFS);
    assign hit_preset = (adr_i == PRESET_OFS);
    assign hit_step   = (adr_i == STEP_OFS);
    assign hit_steps  = (adr_i == STEPS_OFS);
    assign hit_wraps  = (adr_i == WRAPS_OFS);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= bus_req && !ack_reg;
        end
    end

    assign ack_o = ack_reg;

    // ---------------------------------------------------------------
    // software registers
    // ---------------------------------------------------------------
    logic [2:0]        select_reg;
    logic              cep_n_reg;
    logic              pin_en_reg;
    logic [STAGES-1:0] preset_reg;
    logic              soft_step_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            select_reg <= SEL_RST;
            cep_n_reg  <= CEP_N_RST;
            pin_en_reg <= PIN_EN_RST;
        end else if (bus_wr && hit_ctrl && lane0) begin
            select_reg <= dat_i[CTRL_SEL_LSB +: CTRL_SEL_W];
            cep_n_reg  <= dat_i[CTRL_CEP_BIT];
            pin_en_reg <= dat_i[CTRL_PIN_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            preset_reg <= PRESET_RST;
        end else if (bus_wr && hit_preset && lane0) begin
            preset_reg <= dat_i[STAGES-1:0];
        end
    end

    // one-cycle step pulse from a software write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            soft_step_reg <= 1'b0;
        end else begin
            soft_step_reg <= bus_wr && hit_step && lane0 && dat_i[STEP_GO_BIT];
        end
    end

    // ---------------------------------------------------------------
    // step enable: rising edge of the clock pin or a software step
    // ---------------------------------------------------------------
    logic       edge_clock_d_reg;
    logic [2:0] arm_reg;
    logic       pin_rise;
    logic       step;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            edge_clock_d_reg <= 1'b0;
        end else begin
            edge_clock_d_reg <= edge_clock_s;
        end
    end

    // edge history is trusted only once the synchroniser holds real pin data,
    // so a pin that idles high shows no false edge after reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            arm_reg <= 3'h0;
        end else begin
            arm_reg <= {arm_reg[1:0], 1'b1};
        end
    end

    assign pin_rise = edge_clock_s && !edge_clock_d_reg && arm_reg[2];
    assign step     = (pin_rise && pin_en_reg) || soft_step_reg;

    // ---------------------------------------------------------------
    // next-state logic
    // ---------------------------------------------------------------
    logic [STAGES-1:0] stage_reg;
    logic [STAGES-1:0] stage_next;
    logic              count_ok;
    logic              up_serial;
    logic              wrap;

    assign count_ok  = !cep_n_reg && !trickle_n_s;
    // the trickle line doubles as serial data when cascaded
    assign up_serial = trickle_n_s;

    always_comb begin
        stage_next = stage_reg;
        wrap       = 1'b0;
        case (select_reg)
            SEL_LOAD: begin
                stage_next = preset_reg;
            end
            SEL_SDOWN: begin
                stage_next = {serial_down_s, stage_reg[STAGES-1:1]};
            end
            SEL_SUP: begin
                stage_next = {stage_reg[STAGES-2:0], up_serial};
            end
            SEL_CDOWN: begin
                if (count_ok) begin
                    stage_next = stage_reg - 4'h1;
                    wrap       = (stage_reg == STAGE_MIN);
                end
            end
            SEL_CUP: begin
                if (count_ok) begin
                    stage_next = stage_reg + 4'h1;
                    wrap       = (stage_reg == STAGE_MAX);
                end
            end
            SEL_HOLD: begin
                stage_next = stage_reg;
            end
            SEL_COMPL: begin
                stage_next = ~stage_reg;
            end
            SEL_CLEAR: begin
                stage_next = STAGE_RST;
            end
            default: begin
                stage_next = stage_reg;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // the four stages: master clear acts without the clock
    // ---------------------------------------------------------------
    // release of master clear is synchronised: the stages stay clear two more edges
    logic [1:0] mclr_hold_reg;

    always_ff @(posedge clk_i or posedge master_clear_i) begin
        if (master_clear_i) begin
            mclr_hold_reg <= 2'h3;
        end else if (rst_i) begin
            mclr_hold_reg <= 2'h0;
        end else begin
            mclr_hold_reg <= {mclr_hold_reg[0], 1'b0};
        end
    end

    always_ff @(posedge clk_i or posedge master_clear_i) begin
        if (master_clear_i) begin
            stage_reg <= STAGE_RST;
        end else if (rst_i || mclr_hold_reg[1]) begin
            stage_reg <= STAGE_RST;
        end else if (step) begin
            stage_reg <= stage_next;
        end
    end

    assign q_o = stage_reg;

    // ---------------------------------------------------------------
    // terminal count
    // ---------------------------------------------------------------
    logic tc_n;

    always_comb begin
        case (select_reg)
            SEL_CUP: begin
                tc_n = !(stage_reg == STAGE_MAX);
            end
            SEL_CDOWN: begin
                tc_n = !(stage_reg == STAGE_MIN);
            end
            SEL_SUP, SEL_SDOWN: begin
                tc_n = stage_reg[STAGES-1];
            end
            default: begin
                tc_n = 1'b1;
            end
        endcase
    end

    assign terminal_count_n_o = tc_n;

    // ---------------------------------------------------------------
    // activity counters, cleared by any write to them
    // ---------------------------------------------------------------
    logic [CW-1:0] steps_reg;
    logic [CW-1:0] wraps_reg;

    // a step in the clearing cycle still counts
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            steps_reg <= '0;
        end else if (bus_wr && hit_steps) begin
            steps_reg <= {{(CW-1){1'b0}}, step};
        end else if (step) begin
            steps_reg <= steps_reg + {{(CW-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wraps_reg <= '0;
        end else if (bus_wr && hit_wraps) begin
            wraps_reg <= {{(CW-1){1'b0}}, step && wrap};
        end else if (step && wrap) begin
            wraps_reg <= wraps_reg + {{(CW-1){1'b0}}, 1'b1};
        end
    end

    // ---------------------------------------------------------------
    // read mux, registered as ack rises
    // ---------------------------------------------------------------
    logic [WB_DW-1:0] rd_mux;
    logic [WB_DW-1:0] dat_reg;

    always_comb begin
        rd_mux = '0;
        case (adr_i)
            CTRL_OFS: begin
                rd_mux[CTRL_SEL_LSB +: CTRL_SEL_W] = select_reg;
                rd_mux[CTRL_CEP_BIT]               = cep_n_reg;
                rd_mux[CTRL_PIN_BIT]               = pin_en_reg;
            end
            PRESET_OFS: begin
                rd_mux[STAGES-1:0] = preset_reg;
            end
            STATUS_OFS: begin
                rd_mux[STAT_Q_LSB +: STAGES] = stage_reg;
                rd_mux[STAT_TC_BIT]          = tc_n;
                rd_mux[STAT_CET_BIT]         = trickle_n_s;
                rd_mux[STAT_SDN_BIT]         = serial_down_s;
            end
            STEPS_OFS: begin
                rd_mux[CW-1:0] = steps_reg;
            end
            WRAPS_OFS: begin
                rd_mux[CW-1:0] = wraps_reg;
            end
            default: begin
                rd_mux = '0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_reg <= '0;
        end else if (bus_req && !ack_reg && !we_i) begin
            dat_reg <= rd_mux;
        end
    end

    assign dat_o = dat_reg;

endmodule

`default_nettype wire

// ===== hdl/cs4_pkg.sv
`default_nettype none

package cs4_pkg;

    localparam int STAGES = 4;
    localparam int WB_AW  = 8;
    localparam int WB_DW  = 32;
    localparam int CNT_W  = 16;

    // register byte offsets
    localparam logic [WB_AW-1:0] CTRL_OFS   = 8'h00;
    localparam logic [WB_AW-1:0] PRESET_OFS = 8'h04;
    localparam logic [WB_AW-1:0] STEP_OFS   = 8'h08;
    localparam logic [WB_AW-1:0] STATUS_OFS = 8'h0c;
    localparam logic [WB_AW-1:0] STEPS_OFS  = 8'h10;
    localparam logic [WB_AW-1:0] WRAPS_OFS  = 8'h14;

    // control field positions
    localparam int CTRL_SEL_LSB  = 0;
    localparam int CTRL_SEL_W    = 3;
    localparam int CTRL_CEP_BIT  = 3;
    localparam int CTRL_PIN_BIT  = 4;

    // status field positions
    localparam int STAT_Q_LSB    = 0;
    localparam int STAT_TC_BIT   = 4;
    localparam int STAT_CET_BIT  = 5;
    localparam int STAT_SDN_BIT  = 6;

    localparam int STEP_GO_BIT   = 0;

    // select codes, written {s2, s1, s0}
    localparam logic [2:0] SEL_LOAD   = 3'h0;
    localparam logic [2:0] SEL_CDOWN  = 3'h1;
    localparam logic [2:0] SEL_SDOWN  = 3'h2;
    localparam logic [2:0] SEL_CUP    = 3'h3;
    localparam logic [2:0] SEL_COMPL  = 3'h4;
    localparam logic [2:0] SEL_CLEAR  = 3'h5;
    localparam logic [2:0] SEL_SUP    = 3'h6;
    localparam logic [2:0] SEL_HOLD   = 3'h7;

    // reset values
    localparam logic [2:0]        SEL_RST    = SEL_HOLD;
    localparam logic              CEP_N_RST  = 1'b0;
    localparam logic              PIN_EN_RST = 1'b1;
    localparam logic [STAGES-1:0] PRESET_RST = 4'h0;
    localparam logic [STAGES-1:0] STAGE_RST  = 4'h0;
    localparam logic [STAGES-1:0] STAGE_MAX  = 4'hf;
    localparam logic [STAGES-1:0] STAGE_MIN  = 4'h0;

endpackage

`default_nettype wire

// ===== hdl/cs4_sync.sv
`default_nettype none

// two-flop synchroniser for pin inputs
module cs4_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= async_i;
            sync_reg <= meta_reg;
        end
    end

    assign sync_o = sync_reg;

endmodule

`default_nettype wire
